// ### core/isl_pkg.sv
// Purpose: Shared types and constants for the interrupt source logic
// Assumes: One 100 MHz clock, all inputs synchronous to it
// Notes: No register bus; selects and enables arrive as plain ports
package isl_pkg;
   localparam int ADDR_W = 20;
   localparam int KEY_N = 4;
   localparam int EXT_N = 6;
   localparam int MATCH_N = 4;
   localparam logic [1:0] PC_OFS_SHORT = 2'h1;
   localparam logic [1:0] PC_OFS_LONG = 2'h2;
   localparam logic SEL_TIMER = 1'h0;
   localparam logic SEL_SERIAL3 = 1'h0;
   localparam int INT4_IDX = 4;
   localparam logic PIN_IDLE = 1'h1;

   // Cause select bits that steer the shared vectors and edge polarity
   typedef struct packed {
      logic bus_collision0_select;
      logic bus_collision1_select;
      logic int4_serial_select;
      logic serial3_cause_select;
      logic [EXT_N-1:0] ext_both_edge;
   } isl_cause_t;

   // Peripheral request strobes feeding shared vectors
   typedef struct packed {
      logic timer_b3;
      logic uart0_collision;
      logic timer_b4;
      logic uart1_collision;
      logic serial3;
   } isl_periph_t;

   // Request pulses toward the interrupt control registers
   typedef struct packed {
      logic [EXT_N-1:0] ext_int;
      logic nmi;
      logic key;
      logic can0_wake;
      logic shared_b3;
      logic shared_b4;
      logic shared_s3;
      logic [MATCH_N-1:0] match;
   } isl_req_t;
endpackage : isl_pkg

// ### core/isl_edge_det.sv
// Purpose: Edge detector for one external interrupt input
// Assumes: Input already synchronous to clk
// Notes: Both-edge mode ignores the polarity bit
`timescale 1ns/1ns
module isl_edge_det (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin and mode
   input wire logic pin,
   input wire logic rising_sel,
   input wire logic both_sel,
   // Request
   output logic pulse
);
   logic prev_q;
   logic prev_d;
   logic pulse_q;
   logic pulse_d;

   always_comb begin
      prev_d = pin;
      if (both_sel) begin
         pulse_d = pin ^ prev_q;
      end else if (rising_sel) begin
         pulse_d = pin & ~prev_q;
      end else begin
         pulse_d = ~pin & prev_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'h1;
         pulse_q <= 1'h0;
      end else begin
         prev_q <= prev_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulse = pulse_q;
endmodule : isl_edge_det

// ### core/isl_addr_match.sv
// Purpose: One address match comparator with stacked PC offset
// Assumes: Fetch address valid with fetch strobe
// Notes: Offset chosen from opcode class flag
`timescale 1ns/1ns
module isl_addr_match #(
   parameter int AW = isl_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Setup
   input wire logic enable,
   input wire logic [AW-1:0] match_address,
   // Fetch
   input wire logic fetch_valid,
   input wire logic [AW-1:0] fetch_addr,
   input wire logic short_form,
   // Result
   output logic hit,
   output logic [AW-1:0] ret_pc
);
   logic hit_q;
   logic hit_d;
   logic [AW-1:0] ret_q;
   logic [AW-1:0] ret_d;

   always_comb begin
      hit_d = enable & fetch_valid & (fetch_addr == match_address);
      ret_d = ret_q;
      if (hit_d) begin
         // Two-byte step for long or short-immediate forms, else one
         ret_d = match_address + AW'(short_form ? isl_pkg::PC_OFS_LONG
                                                 : isl_pkg::PC_OFS_SHORT);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'h0;
         ret_q <= '0;
      end else begin
         hit_q <= hit_d;
         ret_q <= ret_d;
      end
   end

   assign hit = hit_q;
   assign ret_pc = ret_q;
endmodule : isl_addr_match

// ### core/isl_top.sv
// What this block does
// - Select bit 0 picks timer B3, else UART0 collision
// - Select bit 1 picks timer B4, else UART1 collision
// - NMI falling edge raises unmaskable request
// - NMI pin level readable as status bit
// - Low input-configured key pin raises key request
// - Held low key pin blocks other key requests
// - Key request wakes wait or stop mode
// - CAN receive falling edge wakes, only in CAN mode
// - Four address matches raise request before execution
// - Each match gated by its own enable
// - Match requests ignore interrupt flag and level
// - Stacked PC is match plus two or one
// - No match detection on 8-bit external areas
// - Each external input edge follows its polarity bit unless its both-edge bit is set
// - Int4 select 1 serves external interrupt 4
//
// Purpose: Interrupt source detection and vector sharing
// Assumes: All inputs synchronous to clk; requests are one-cycle pulses
// Notes: Flag setting and priority resolution live in the control registers
`timescale 1ns/1ns
module isl_top #(
   parameter int KEY_N = isl_pkg::KEY_N,
   parameter int EXT_N = isl_pkg::EXT_N,
   parameter int MATCH_N = isl_pkg::MATCH_N,
   parameter int AW = isl_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire isl_pkg::isl_cause_t cause,
   input wire logic [EXT_N-1:0] polarity_select,
   input wire logic [KEY_N-1:0] key_pin_direction,
   input wire logic can_port_mode,
   input wire logic [MATCH_N-1:0] match_enable,
   input wire logic [MATCH_N*AW-1:0] match_address,
   input wire logic ext_bus_8bit,
   input wire logic low_power_mode,
   // Pins and peripherals
   input wire logic [EXT_N-1:0] ext_int_pin,
   input wire logic nonmaskable_request_pin,
   input wire logic [KEY_N-1:0] key_pin,
   input wire logic can_receive_input,
   input wire isl_pkg::isl_periph_t periph,
   // CPU fetch
   input wire logic fetch_valid,
   input wire logic [AW-1:0] fetch_addr,
   input wire logic fetch_external,
   input wire logic short_form,
   // Requests and status
   output isl_pkg::isl_req_t req,
   output logic nmi_level_bit,
   output logic wake,
   output logic [AW-1:0] stacked_pc
);
   // Edge detector and comparator outputs
   logic [EXT_N-1:0] ext_pulse;
   logic [MATCH_N-1:0] hit;
   logic [MATCH_N*AW-1:0] ret_flat;
   // Non-maskable pin history and level
   logic nmi_prev_q;
   logic nmi_prev_d;
   logic nmi_req_q;
   logic nmi_req_d;
   logic nmi_lvl_q;
   logic nmi_lvl_d;
   // Key input aggregate
   logic [KEY_N-1:0] key_low_pin;
   logic any_key_low;
   logic key_low_q;
   logic key_low_d;
   logic key_req_q;
   logic key_req_d;
   // CAN receive wake-up
   logic can_prev_q;
   logic can_prev_d;
   logic can_req_q;
   logic can_req_d;
   // Shared vectors
   logic shared_b3_q;
   logic shared_b3_d;
   logic shared_b4_q;
   logic shared_b4_d;
   logic shared_s3_q;
   logic shared_s3_d;
   // External interrupt routing
   logic [EXT_N-1:0] ext_sel_q;
   logic [EXT_N-1:0] ext_sel_d;
   // Address match requests and return PC
   logic [MATCH_N-1:0] match_q;
   logic [MATCH_N-1:0] match_d;
   logic [AW-1:0] pc_q;
   logic [AW-1:0] pc_d;
   // Wake-up
   logic wake_q;
   logic wake_d;

   // ==========================================
   // External interrupt edges
   genvar gi;
   generate
      for (gi = 0; gi < EXT_N; gi++) begin : g_ext
         isl_edge_det u_edge (
            .clk(clk),
            .rst_n(rst_n),
            .pin(ext_int_pin[gi]),
            .rising_sel(polarity_select[gi]),
            .both_sel(cause.ext_both_edge[gi]),
            .pulse(ext_pulse[gi])
         );
      end
   endgenerate

   // ==========================================
   // Address match comparators
   generate
      for (gi = 0; gi < MATCH_N; gi++) begin : g_match
         isl_addr_match #(.AW(AW)) u_match (
            .clk(clk),
            .rst_n(rst_n),
            .enable(match_enable[gi]),
            .match_address(match_address[gi*AW +: AW]),
            .fetch_valid(fetch_valid & ~(ext_bus_8bit & fetch_external)),
            .fetch_addr(fetch_addr),
            .short_form(short_form),
            .hit(hit[gi]),
            .ret_pc(ret_flat[gi*AW +: AW])
         );
      end
   endgenerate

   // ==========================================
   // Decode helpers
   // Timer request when the select bit is clear, collision request when set
   function automatic logic pick_shared(input logic sel, input logic timer_req,
                                        input logic collision_req);
      logic res;
      if (sel == isl_pkg::SEL_TIMER) begin
         res = timer_req;
      end else begin
         res = collision_req;
      end
      return res;
   endfunction : pick_shared

   // High-to-low step between the last sample and this one
   function automatic logic fell_now(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction : fell_now

   // ==========================================
   // Shared vector selection
   always_comb begin
      shared_b3_d = pick_shared(cause.bus_collision0_select, periph.timer_b3,
                                periph.uart0_collision);
      shared_b4_d = pick_shared(cause.bus_collision1_select, periph.timer_b4,
                                periph.uart1_collision);
      // Serial I/O3 owns the vector only while int4 is not selected
      shared_s3_d = (cause.int4_serial_select == isl_pkg::SEL_SERIAL3) & periph.serial3;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shared_b3_q <= 1'h0;
         shared_b4_q <= 1'h0;
         shared_s3_q <= 1'h0;
      end else begin
         shared_b3_q <= shared_b3_d;
         shared_b4_q <= shared_b4_d;
         shared_s3_q <= shared_s3_d;
      end
   end

   // ==========================================
   // Non-maskable request and pin level
   always_comb begin
      nmi_prev_d = nonmaskable_request_pin;
      nmi_req_d = fell_now(nmi_prev_q, nonmaskable_request_pin);
      nmi_lvl_d = nonmaskable_request_pin;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_prev_q <= isl_pkg::PIN_IDLE;
         nmi_req_q <= 1'h0;
         nmi_lvl_q <= isl_pkg::PIN_IDLE;
      end else begin
         nmi_prev_q <= nmi_prev_d;
         nmi_req_q <= nmi_req_d;
         nmi_lvl_q <= nmi_lvl_d;
      end
   end

   // ==========================================
   // Key input request
   // Per-pin low detect, only for input-configured key pins
   generate
      for (gi = 0; gi < KEY_N; gi++) begin : g_key
         assign key_low_pin[gi] = ~key_pin[gi] & ~key_pin_direction[gi];
      end
   endgenerate

   always_comb begin
      any_key_low = |key_low_pin;
      key_low_d = any_key_low;
      key_req_d = any_key_low & ~key_low_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         key_low_q <= 1'h0;
         key_req_q <= 1'h0;
      end else begin
         key_low_q <= key_low_d;
         key_req_q <= key_req_d;
      end
   end

   // ==========================================
   // CAN receive wake-up
   always_comb begin
      can_prev_d = can_receive_input;
      can_req_d = can_port_mode & fell_now(can_prev_q, can_receive_input);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         can_prev_q <= isl_pkg::PIN_IDLE;
         can_req_q <= 1'h0;
      end else begin
         can_prev_q <= can_prev_d;
         can_req_q <= can_req_d;
      end
   end

   // ==========================================
   // External interrupt routing
   always_comb begin
      ext_sel_d = ext_pulse;
      // Int4 vector goes to serial I/O3 unless selected
      ext_sel_d[isl_pkg::INT4_IDX] = cause.int4_serial_select
                                     & ext_pulse[isl_pkg::INT4_IDX];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_sel_q <= '0;
      end else begin
         ext_sel_q <= ext_sel_d;
      end
   end

   // ==========================================
   // Address match requests and stacked PC
   always_comb begin
      match_d = hit;
      pc_d = pc_q;
      // Highest index wins when several match in one cycle
      for (int i = 0; i < MATCH_N; i++) begin
         if (hit[i]) begin
            pc_d = ret_flat[i*AW +: AW];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         match_q <= '0;
         pc_q <= '0;
      end else begin
         match_q <= match_d;
         pc_q <= pc_d;
      end
   end

   // ==========================================
   // Wake-up from wait or stop
   always_comb begin
      wake_d = low_power_mode & (key_req_d | can_req_d | nmi_req_d);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_q <= 1'h0;
      end else begin
         wake_q <= wake_d;
      end
   end

   // ==========================================
   // Outputs
   assign req = '{ext_int: ext_sel_q, nmi: nmi_req_q, key: key_req_q, can0_wake: can_req_q,
                  shared_b3: shared_b3_q, shared_b4: shared_b4_q, shared_s3: shared_s3_q,
                  match: match_q};
   assign nmi_level_bit = nmi_lvl_q;
   assign wake = wake_q;
   assign stacked_pc = pc_q;
endmodule : isl_top

// ### dv/isl_chk.sv
// Purpose: Port assertions for isl_top
// Assumes: One clock, rst_n async active low
// Notes: Bound from the testbench top file
`timescale 1ns/1ns
module isl_chk #(
   parameter int KEY_N = 4,
   parameter int EXT_N = 6,
   parameter int MATCH_N = 4,
   parameter int AW = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Watched inputs
   input wire isl_pkg::isl_cause_t cause,
   input wire logic [EXT_N-1:0] polarity_select,
   input wire logic [KEY_N-1:0] key_pin_direction,
   input wire logic can_port_mode,
   input wire logic [MATCH_N-1:0] match_enable,
   input wire logic [MATCH_N*AW-1:0] match_address,
   input wire logic ext_bus_8bit,
   input wire logic [EXT_N-1:0] ext_int_pin,
   input wire logic nonmaskable_request_pin,
   input wire logic [KEY_N-1:0] key_pin,
   input wire logic can_receive_input,
   input wire isl_pkg::isl_periph_t periph,
   input wire logic fetch_valid,
   input wire logic [AW-1:0] fetch_addr,
   input wire logic fetch_external,
   input wire logic short_form,
   // Watched outputs
   input wire isl_pkg::isl_req_t req,
   input wire logic nmi_level_bit,
   input wire logic [AW-1:0] stacked_pc
);
   // ==========
   // Helpers
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic key_low;
   assign key_low = |(~key_pin & ~key_pin_direction);
   sequence s_fetch0;
      fetch_valid && match_enable[0] && fetch_addr == match_address[AW-1:0]
         && !(ext_bus_8bit && fetch_external);
   endsequence
   sequence s_hit0;
      req.match[0] && stacked_pc == $past(fetch_addr, 2) + AW'($past(short_form, 2) ? 2 : 1);
   endsequence
   // ==========
   // Assertions
   a_nmi_fall: assert property ($fell(nonmaskable_request_pin) |=> req.nmi)
      else $error("nmi request missing");
   a_nmi_level: assert property (nmi_level_bit == $past(nonmaskable_request_pin))
      else $error("nmi level wrong");
   a_share_b3: assert property (req.shared_b3 == ($past(cause.bus_collision0_select) ?
      $past(periph.uart0_collision) : $past(periph.timer_b3))) else $error("b3 share wrong");
   a_share_s3: assert property (req.shared_s3 ==
      (!$past(cause.int4_serial_select) && $past(periph.serial3))) else $error("s3 share wrong");
   a_key_rise: assert property ($rose(key_low) |=> req.key)
      else $error("key request missing");
   a_key_hold: assert property ($past(key_low) |=> !req.key)
      else $error("key request while held");
   a_can_wake: assert property (can_port_mode && $fell(can_receive_input) |=> req.can0_wake)
      else $error("can wake missing");
   a_ext_edge: assert property (!cause.ext_both_edge[0] && (polarity_select[0] ?
      $rose(ext_int_pin[0]) : $fell(ext_int_pin[0])) |-> ##2 req.ext_int[0])
      else $error("ext edge missed");
   a_ext_both: assert property (cause.ext_both_edge[0] && $changed(ext_int_pin[0])
      |-> ##2 req.ext_int[0]) else $error("both edge missed");
   a_match_hit: assert property (s_fetch0 |-> ##2 s_hit0)
      else $error("match or pc wrong");
   a_match_gate: assert property (req.match[0] |-> $past(match_enable[0], 2) &&
      !($past(ext_bus_8bit, 2) && $past(fetch_external, 2))) else $error("match not gated");
endmodule : isl_chk

// ### dv/isl_cpu.sv
// Purpose: CPU fetch side model
// Assumes: Called from the testbench
// Notes: Idle fetch fields are inverted so stale values never match
`timescale 1ns/1ns
module isl_cpu (
   // Clock
   input wire logic clk,
   // Fetch
   output logic fetch_valid = 1'h0,
   output logic [19:0] fetch_addr = 20'h0,
   output logic fetch_external = 1'h0,
   output logic short_form = 1'h0
);
   task automatic fetch(input logic [19:0] a, input logic sf, input logic ext);
      @(posedge clk);
      fetch_valid <= 1'h1;
      {fetch_addr, short_form, fetch_external} <= {a, sf, ext};
      @(posedge clk);
      fetch_valid <= 1'h0;
      {fetch_addr, short_form, fetch_external} <= ~{a, sf, ext};
   endtask : fetch
endmodule : isl_cpu

// ### dv/test_isl_top.sv
// Purpose: Directed test of isl_top
// Assumes: Inputs driven by NBA at rising edges
// Notes: Tables hold pin steps and expected requests
`timescale 1ns/1ns
module test_isl_top;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   isl_pkg::isl_cause_t cause = 10'h040;
   logic [5:0] polarity_select = 6'h01;
   logic [3:0] key_pin_direction = 4'h4;
   logic can_port_mode = 1'h0;
   logic [3:0] match_enable = 4'hF;
   logic [79:0] match_address = {20'h0400C, 20'h04008, 20'h04004, 20'h04000};
   logic ext_bus_8bit = 1'h0;
   logic low_power_mode = 1'h0;
   logic [5:0] ext_int_pin = 6'h3F;
   logic nonmaskable_request_pin = 1'h1;
   logic [3:0] key_pin = 4'hF;
   logic can_receive_input = 1'h1;
   isl_pkg::isl_periph_t periph = '0;
   logic fetch_valid, fetch_external, short_form, nmi_level_bit, wake;
   logic [19:0] fetch_addr, stacked_pc;
   isl_pkg::isl_req_t req;
   int n_mismatch = 0, checked = 0, n_wake = 0;
   logic [7:0] kt [6] = '{8'hB4, 8'hA2, 8'h84, 8'hFC, 8'hF9, 8'hFC};
   logic [13:0] et [8] = '{14'h1F40, 14'h1FC1, 14'h17D0, 14'h1F80,
                           14'h1780, 14'h00EE, 14'h2041, 14'h20C1};
   always #5 clk = ~clk;
   always @(posedge clk) if (wake === 1'h1) n_wake++;
   isl_top dut (.*);
   isl_cpu cpu (.*);
   // ==========
   // Tasks
   task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic waitn(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : waitn
   task automatic test_done;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (1000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
   // ==========
   // Tests
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         cause[9:7] <= {3{s[0]}};
         periph <= 5'h13;
         @(posedge clk);
         periph <= '0;
         #1;
         chk("shared_b3", req.shared_b3, !s);
         chk("shared_b4", req.shared_b4, s);
         chk("shared_s3", req.shared_s3, !s);
      end
      $display("shared done");
      @(posedge clk);
      nonmaskable_request_pin <= 1'h0;
      waitn(1);
      chk("nmi", req.nmi, 1'h1);
      chk("nmi_level", nmi_level_bit, 1'h0);
      waitn(1);
      chk("nmi_once", req.nmi, 1'h0);
      $display("nmi done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         {key_pin, can_port_mode, can_receive_input} <= kt[i][7:2];
         nonmaskable_request_pin <= 1'h1;
         low_power_mode <= 1'h1;
         waitn(1);
         chk("key_can", {req.key, req.can0_wake}, kt[i][1:0]);
      end
      @(posedge clk);
      low_power_mode <= 1'h0;
      waitn(3);
      chk("wake_count", n_wake, 2);
      $display("key can done");
      for (int i = 0; i < 4; i++) begin
         cpu.fetch(20'h04000 + 20'(4 * i), i[0], 1'h0);
         waitn(1);
         chk("match", req.match[i], 1'h1);
         chk("stacked_pc", stacked_pc, 20'h04000 + 20'(4 * i + 1 + i % 2));
      end
      for (int j = 0; j < 3; j++) begin
         @(posedge clk);
         match_enable <= {3'h7, j != 0};
         ext_bus_8bit <= j != 0;
         cpu.fetch(20'h04000, 1'h0, j == 1);
         waitn(1);
         chk("match_gate", req.match[0], j == 2);
      end
      $display("match done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {cause.ext_both_edge[0], ext_int_pin, cause.int4_serial_select} <= et[i][13:6];
         polarity_select[0] <= !et[i][13];
         waitn(2);
         chk("ext_int", req.ext_int, et[i][5:0]);
      end
      $display("ext done");
      test_done();
   end
endmodule : test_isl_top
bind isl_top isl_chk #(.KEY_N(KEY_N), .EXT_N(EXT_N), .MATCH_N(MATCH_N), .AW(AW)) chk (.*);
